// >>> src/rhpd_regs.vh
// Offsets, field positions, reset values for the root-hub port mask block
`ifndef RHPD_REGS_VH
`define RHPD_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses from the memory base)
// ----------------------------------------------------------------
`define RHPD_OFS_PORT_MASKS   8'h4c
`define RHPD_OFS_HUB_STATUS   8'h50

// ----------------------------------------------------------------
// Port mask register fields and reset value
// ----------------------------------------------------------------
`define RHPD_PWR_MASK_LSB     16
`define RHPD_PWR_MASK_MSB     31
`define RHPD_REMOV_LSB        0
`define RHPD_REMOV_MSB        15
`define RHPD_PORT_MASKS_RST   32'h0006_0000

// ----------------------------------------------------------------
// Hub status word fields
// ----------------------------------------------------------------
`define RHPD_HS_CLR_GLOBAL    0
`define RHPD_HS_OVC_IND       1
`define RHPD_HS_RWAKE_EN      15
`define RHPD_HS_SET_GLOBAL    16
`define RHPD_HS_OVC_CHG       17
`define RHPD_HS_CLR_RWAKE     31

`endif

// >>> src/rhpd_port_power.v
// Power state of one downstream root-hub port
module rhpd_port_power (
    input  wire clk_in,
    input  wire nrst_in,
    input  wire per_port_switch_select_in,
    input  wire port_power_select_mask_in,
    input  wire global_set_in,
    input  wire global_clr_in,
    input  wire port_set_in,
    input  wire port_clr_in,
    output reg  powered_out
);

    wire per_port_ctl;

    // Mask only counts in individual switching mode
    assign per_port_ctl = per_port_switch_select_in &
                          port_power_select_mask_in;

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            powered_out <= 1'b0;
        end else if (per_port_ctl) begin
            // Set wins if both commands land together
            if (port_set_in) begin
                powered_out <= 1'b1;
            end else if (port_clr_in) begin
                powered_out <= 1'b0;
            end
        end else begin
            if (global_set_in) begin
                powered_out <= 1'b1;
            end else if (global_clr_in) begin
                powered_out <= 1'b0;
            end
        end
    end

endmodule // rhpd_port_power

// >>> src/rhpd_top.v
// Root-hub port mask register, hub status word and port power control
`include "rhpd_regs.vh"

module rhpd_top #(
    parameter NUM_PORTS = 2
) (
    input  wire                 clk_in,
    input  wire                 nrst_in,
    input  wire                 acc_sel_in,
    input  wire                 acc_wr_in,
    input  wire [7:0]           acc_addr_in,
    input  wire [31:0]          acc_wdata_in,
    input  wire                 per_port_switch_select_in,
    input  wire                 overcurrent_in,
    input  wire [NUM_PORTS-1:0] port_set_power_in,
    input  wire [NUM_PORTS-1:0] port_clr_power_in,
    output reg  [31:0]          acc_rdata_out,
    output reg                  acc_ack_out,
    output wire [NUM_PORTS-1:0] port_powered_out,
    output reg  [NUM_PORTS-1:0] port_fixed_device_out,
    output reg                  remote_wake_en_out
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg  [31:0] port_masks_q;
    reg         ovc_ind_q;
    reg         ovc_chg_q;
    reg         ovc_chg_d;
    reg         rwake_en_q;
    reg         rwake_en_d;
    reg  [31:0] rdata_d;

    // ------------------------------------------------------------
    // Decode and strobe nets
    // ------------------------------------------------------------
    wire        sel_masks;
    wire        sel_status;
    wire        wr_masks;
    wire        wr_status;
    wire        global_set;
    wire        global_clr;
    wire        ovc_chg_clr;
    wire        rwake_set;
    wire        rwake_clr;
    wire        ovc_edge;
    wire [15:0] port_power_select_mask;
    wire [15:0] device_removable_map;
    wire [15:0] hub_status_lo;
    wire [15:0] hub_status_hi;
    wire [31:0] hub_status_word;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Offset match, only while an access is requested
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = acc_sel_in & (addr == ofs);
        end
    endfunction

    assign sel_masks  = hit(acc_addr_in, `RHPD_OFS_PORT_MASKS);
    assign sel_status = hit(acc_addr_in, `RHPD_OFS_HUB_STATUS);
    assign wr_masks   = sel_masks & acc_wr_in;
    assign wr_status  = sel_status & acc_wr_in;

    // ------------------------------------------------------------
    // Hub status write strobes
    // ------------------------------------------------------------
    // Command bits act on a one; a written zero does nothing
    assign global_set  = wr_status & acc_wdata_in[`RHPD_HS_SET_GLOBAL];
    assign global_clr  = wr_status & acc_wdata_in[`RHPD_HS_CLR_GLOBAL];
    assign ovc_chg_clr = wr_status & acc_wdata_in[`RHPD_HS_OVC_CHG];
    assign rwake_set   = wr_status & acc_wdata_in[`RHPD_HS_RWAKE_EN];
    assign rwake_clr   = wr_status & acc_wdata_in[`RHPD_HS_CLR_RWAKE];

    // ------------------------------------------------------------
    // Mask register, all bits read/write
    // ------------------------------------------------------------
    // Unused bits are kept so software reads back what it wrote
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port_masks_q <= `RHPD_PORT_MASKS_RST;
        end else if (wr_masks) begin
            port_masks_q <= acc_wdata_in;
        end
    end

    assign port_power_select_mask =
        port_masks_q[`RHPD_PWR_MASK_MSB:`RHPD_PWR_MASK_LSB];
    assign device_removable_map =
        port_masks_q[`RHPD_REMOV_MSB:`RHPD_REMOV_LSB];

    // ------------------------------------------------------------
    // Overcurrent indicator and its change flag
    // ------------------------------------------------------------
    assign ovc_edge = overcurrent_in ^ ovc_ind_q;

    always @* begin
        ovc_chg_d = ovc_chg_q;
        // A new change beats a clear in the same cycle
        if (ovc_edge) begin
            ovc_chg_d = 1'b1;
        end else if (ovc_chg_clr) begin
            ovc_chg_d = 1'b0;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ovc_ind_q <= 1'b0;
            ovc_chg_q <= 1'b0;
        end else begin
            ovc_ind_q <= overcurrent_in;
            ovc_chg_q <= ovc_chg_d;
        end
    end

    // ------------------------------------------------------------
    // Remote wake enable
    // ------------------------------------------------------------
    always @* begin
        rwake_en_d = rwake_en_q;
        // Set wins when software sets and clears in one write
        if (rwake_set) begin
            rwake_en_d = 1'b1;
        end else if (rwake_clr) begin
            rwake_en_d = 1'b0;
        end
    end

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rwake_en_q         <= 1'b0;
            remote_wake_en_out <= 1'b0;
        end else begin
            rwake_en_q         <= rwake_en_d;
            remote_wake_en_out <= rwake_en_q;
        end
    end

    // ------------------------------------------------------------
    // Hub status word layout
    // ------------------------------------------------------------
    // Status in low half, change bits in high half
    assign hub_status_lo = {rwake_en_q, 13'h0000, ovc_ind_q, 1'b0};
    assign hub_status_hi = {14'h0000, ovc_chg_q, 1'b0};
    assign hub_status_word = {hub_status_hi, hub_status_lo};

    // ------------------------------------------------------------
    // Read data select
    // ------------------------------------------------------------
    // Last answer stands while the bus is idle
    always @* begin
        rdata_d = acc_rdata_out;
        if (sel_masks) begin
            rdata_d = port_masks_q;
        end else if (sel_status) begin
            // Reserved bits read back as zero, per write-zero use
            rdata_d = hub_status_word;
        end else if (acc_sel_in) begin
            rdata_d = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Bus answer, one cycle after each access
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_rdata_out <= 32'h0000_0000;
            acc_ack_out   <= 1'b0;
        end else begin
            acc_rdata_out <= rdata_d;
            acc_ack_out   <= acc_sel_in;
        end
    end

    // ------------------------------------------------------------
    // Removability report, ports 1..NUM_PORTS
    // ------------------------------------------------------------
    // Bit 0 and bits above NUM_PORTS are never looked at
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port_fixed_device_out <= {NUM_PORTS{1'b0}};
        end else begin
            port_fixed_device_out <=
                device_removable_map[NUM_PORTS:1];
        end
    end

    // ------------------------------------------------------------
    // Per-port power, ports 1..NUM_PORTS
    // ------------------------------------------------------------
    // Mask bit 0 is reserved, so port n uses mask bit n
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
            rhpd_port_power u_pwr (
                .clk_in                    (clk_in),
                .nrst_in                   (nrst_in),
                .per_port_switch_select_in (per_port_switch_select_in),
                .port_power_select_mask_in (port_power_select_mask[gi+1]),
                .global_set_in             (global_set),
                .global_clr_in             (global_clr),
                .port_set_in               (port_set_power_in[gi]),
                .port_clr_in               (port_clr_power_in[gi]),
                .powered_out               (port_powered_out[gi])
            );
        end
    endgenerate

endmodule // rhpd_top

// >>> dv/rhpd_chk.sv
// Checker for the root-hub port mask block, bound to its top module
module rhpd_chk #(
    parameter NUM_PORTS = 2
) (
    input wire logic                 clk_in,
    input wire logic                 nrst_in,
    input wire logic                 acc_sel_in,
    input wire logic                 acc_wr_in,
    input wire logic [7:0]           acc_addr_in,
    input wire logic [31:0]          acc_wdata_in,
    input wire logic                 per_port_switch_select_in,
    input wire logic [NUM_PORTS-1:0] port_set_power_in,
    input wire logic [31:0]          acc_rdata_out,
    input wire logic                 acc_ack_out,
    input wire logic [NUM_PORTS-1:0] port_powered_out,
    input wire logic [NUM_PORTS-1:0] port_fixed_device_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Shadow of the mask register, rebuilt from the bus traffic
    logic [31:0] mask_q;
    wire rd_w = acc_sel_in & ~acc_wr_in;
    wire wr_w = acc_sel_in & acc_wr_in;
    wire hs_w = wr_w & (acc_addr_in == 8'h50);
    always_ff @(posedge clk_in or negedge nrst_in)
        if (!nrst_in) mask_q <= 32'h0006_0000;
        else if (wr_w && acc_addr_in == 8'h4c) mask_q <= acc_wdata_in;
    a_ack_follows: assert property (acc_sel_in |=> acc_ack_out)
        else $error("access not acknowledged");
    a_mask_read: assert property (rd_w && acc_addr_in == 8'h4c
        |=> acc_rdata_out == $past(mask_q)) else $error("mask readback");
    a_unmapped_zero: assert property (rd_w && acc_addr_in != 8'h4c
        && acc_addr_in != 8'h50 |=> acc_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_hub_halves: assert property (rd_w && acc_addr_in == 8'h50
        |=> (acc_rdata_out & 32'hfffd_7ffd) == 32'h0)
        else $error("hub status stray bits");
    a_fixed_map: assert property ($past(nrst_in)
        |-> port_fixed_device_out == $past(mask_q[NUM_PORTS:1]))
        else $error("fixed device map");
    a_global_set: assert property (hs_w && acc_wdata_in[16]
        && !per_port_switch_select_in |=> &port_powered_out)
        else $error("global set power");
    a_port_set: assert property (
        per_port_switch_select_in && mask_q[17]
        && port_set_power_in[0] |=> port_powered_out[0])
        else $error("per-port set power");
    a_unmasked_hold: assert property (per_port_switch_select_in
        && !mask_q[18] && !hs_w |=> $stable(port_powered_out[1]))
        else $error("unmasked port moved");
    cover property (wr_w && acc_addr_in == 8'h4c);
    cover property (per_port_switch_select_in && mask_q[17] && hs_w);
    cover property (rd_w && acc_addr_in == 8'h50 ##1 acc_rdata_out[17]);
endmodule // rhpd_chk

bind rhpd_top rhpd_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

// >>> dv/root_hub_port_descriptor_tb.sv
// Self-checking bench for the root-hub port mask block
module root_hub_port_descriptor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, nrst = 0, sel = 0, wr = 0, mode = 0, oc = 0;
    logic        gs, gc, ack, wake;
    logic [7:0]  addr = 0, a;
    logic [31:0] wdata = 0, rd, m, rdata;
    logic [1:0]  ps = 0, pc = 0, ep, pwr, fix;
    int          fail_count = 0, checks_done = 0;
    always #5 clk = ~clk;
    rhpd_top u_dut (.clk_in(clk), .nrst_in(nrst), .acc_sel_in(sel),
        .acc_wr_in(wr), .acc_addr_in(addr), .acc_wdata_in(wdata),
        .per_port_switch_select_in(mode), .overcurrent_in(oc),
        .port_set_power_in(ps), .port_clr_power_in(pc),
        .acc_rdata_out(rdata), .acc_ack_out(ack), .port_powered_out(pwr),
        .port_fixed_device_out(fix), .remote_wake_en_out(wake));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // One access a cycle; select stays up until the caller idles the bus
    task automatic acc(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        sel = 1;
        wr = w;
        addr = ad;
        wdata = d;
        @(posedge clk);
        #1;
        rd = rdata;
        chk({31'h0, ack}, 32'h1);
    endtask
    // Expected port power after one cycle of commands
    function automatic logic [1:0] pmod(logic [1:0] p, logic md,
        logic [31:0] mk, logic s_g, logic c_g, logic [1:0] s, logic [1:0] c);
        for (int i = 0; i < 2; i++)
            if (!md || !mk[17+i]) begin
                if (s_g) p[i] = 1'b1;
                else if (c_g) p[i] = 1'b0;
            end else if (s[i]) p[i] = 1'b1;
            else if (c[i]) p[i] = 1'b0;
        return p;
    endfunction
    task automatic give_verdict;
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(32'ha7c474b3));
        repeat (12) @(posedge clk);
        #1 nrst = 1;
        acc(0, 8'h4c, 0);
        chk(rd, 32'h0006_0000);
        ep = 2'b00;
        repeat (30) begin
            m = $urandom;
            acc(1, 8'h4c, m);
            acc(0, 8'h4c, 0);
            chk(rd, m);
            chk({30'h0, fix}, {30'h0, m[2:1]});
            a = $urandom;
            if (a == 8'h4c || a == 8'h50) a = 8'h54;
            acc(1, a, ~m);
            acc(0, a, 0);
            chk(rd, 32'h0);
            acc(0, 8'h4c, 0);
            chk(rd, m);
            repeat (6) begin
                mode = $urandom;
                {gs, gc, ps, pc} = $urandom;
                ep = pmod(ep, mode, m, gs, gc, ps, pc);
                acc(1, 8'h50, {15'h0, gs, 15'h0, gc});
                chk({30'h0, pwr}, {30'h0, ep});
            end
            ps = 0;
            pc = 0;
        end
        acc(1, 8'h50, 32'h0000_8000);
        acc(0, 8'h50, 0);
        chk(rd, 32'h0000_8000);
        chk({31'h0, wake}, 32'h1);
        acc(1, 8'h50, 32'h8000_0000);
        sel = 0;
        oc = 1;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, wake}, 32'h0);
        acc(0, 8'h50, 0);
        chk(rd, 32'h0002_0002);
        sel = 0;
        oc = 0;
        repeat (3) @(posedge clk);
        #1;
        acc(1, 8'h50, 32'h0002_0000);
        acc(0, 8'h50, 0);
        chk(rd, 32'h0);
        give_verdict();
    end
endmodule // root_hub_port_descriptor_tb
